// [dv/tb_user_timing_pulse_generator.sv]
`timescale 1ns/1ps
// Self-checking bench for the user timing outputs
module tb_user_timing_pulse_generator;
   logic        CLK = 1'b0, RST = 1'b1, REG_WE = 1'b0, chk = 1'b0;
   logic        H_SYNC, V_SYNC, hp, vp;  // Syncs and their last samples
   logic [7:0]  REG_ADDR = 8'h00;
   logic [11:0] REG_WDATA = 12'h000, MODE_SEL = 12'h000;
   logic [3:0]  POL_LOW = 4'h0, USER_OUT, e1, e2;  // e1/e2: expected, lagged
   logic [11:0] REG_RDATA, PIX_COUNT, LINE_COUNT, pix, line;
   logic [11:0] regs [16];  // Shadow of the timing registers
   int          miscompares, n_checks, cyc;
   always #25 CLK = ~CLK;
   utpg_raster u_ras (.CLK(CLK), .RST(RST), .H_SYNC(H_SYNC), .V_SYNC(V_SYNC));
   utpg_top u_dut (.CLK(CLK), .RST(RST), .H_SYNC(H_SYNC), .V_SYNC(V_SYNC),
      .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .POL_LOW(POL_LOW),
      .MODE_SEL(MODE_SEL), .REG_RDATA(REG_RDATA), .USER_OUT(USER_OUT),
      .PIX_COUNT(PIX_COUNT), .LINE_COUNT(LINE_COUNT));
   task automatic check(string nm, logic [11:0] got, logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic results();
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   // Expected pulse of output g from the reference counts
   function automatic logic pulse(int g);
      logic h, v;
      h = regs[4*g] <= pix && pix <= regs[4*g+1];
      v = regs[4*g+2] <= line && line <= regs[4*g+3];
      case (MODE_SEL[3*g+:3])
         3'h0: pulse = h;
         3'h1: pulse = v;
         3'h3: pulse = h | v;
         3'h4: pulse = h ^ v;
         default: pulse = h & v;  // Unused codes behave as AND
      endcase
      pulse = pulse ^ POL_LOW[g];
   endfunction : pulse
   // Reference counts restart on sync leading edges; V wins over H
   always @(posedge CLK) begin
      if (RST) begin
         {pix, line, hp, vp} = '0;
      end else begin
         line = (V_SYNC && !vp) ? 12'h000 : line + 12'((H_SYNC && !hp) && line != 12'hfff);
         pix = (H_SYNC && !hp) ? 12'h000 : pix + 12'(pix != 12'hfff);
         hp = H_SYNC;
         vp = V_SYNC;
      end
   end
   // Compare on settled outputs; a hang ends the run
   always @(negedge CLK) begin
      if (chk) begin
         check("pix", PIX_COUNT, pix);
         check("line", LINE_COUNT, line);
         check("user", {8'h00, USER_OUT}, {8'h00, e2});
      end
      e2 = e1;
      for (int g = 0; g < 4; g++) e1[g] = pulse(g);
      if (++cyc > 2000) begin
         miscompares++;
         results();
      end
   end
   // Strobe stays up between writes; caller lowers it
   task automatic wr(logic [7:0] a, logic [11:0] d);
      REG_WE = 1'b1;
      REG_ADDR = a;
      REG_WDATA = d;
      @(negedge CLK);
      if (a >= 8'h57 && a <= 8'h66) regs[a-8'h57] = d;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [11:0] e);
      REG_ADDR = a;
      @(negedge CLK);
      check("rdata", REG_RDATA, e);
   endtask : rd
   // Reset value, full map written back to back, neighbours unmapped
   task automatic t_regs();
      rd(8'h57, 12'h000);
      for (int i = 0; i < 18; i++) wr(8'h56 + 8'(i), 12'(i * 233 + 7));
      REG_WE = 1'b0;
      for (int i = 0; i < 18; i++) rd(8'h56 + 8'(i), (i > 0 && i < 17) ? regs[i-1] : 12'h000);
   endtask : t_regs
   // Windows per output; h3 overrides output 3 start
   task automatic t_run(logic [11:0] m, logic [3:0] p, logic [11:0] h3);
      chk = 1'b0;
      for (int k = 0; k < 16; k++)
         wr(8'h57 + 8'(k), 12'(k%4 == 0 ? 2+k/4 : k%4 == 1 ? 5+k/2 : k%4 == 2 ? 1+k/4%2 : 2+k/4));
      wr(8'h63, h3);
      REG_WE = 1'b0;
      MODE_SEL = m;
      POL_LOW = p;
      repeat (3) @(negedge CLK);
      chk = 1'b1;
      repeat (250) @(negedge CLK);
   endtask : t_run
   initial begin
      repeat (12) @(negedge CLK);
      RST = 1'b0;
      t_regs();
      t_run(12'h688, 4'h0, 12'h005);
      t_run(12'h1ec, 4'ha, 12'h0ff);
      results();
   end
endmodule : tb_user_timing_pulse_generator

// [dv/utpg_raster.sv]
`timescale 1ns/1ps
// Stand-in for the main timing generator
module utpg_raster #(
   parameter int HT = 20,  // Pixels per line, short to keep runs brief
   parameter int VT = 6    // Lines per frame
) (
   input  wire logic CLK,
   input  wire logic RST,
   output      logic H_SYNC = 1'b0,  // High for two pixels
   output      logic V_SYNC = 1'b0   // High through line 0
);
   int px;  // Pixel in line
   int ln;  // Line in frame
   // Falling edge, so the sampling edge sees settled syncs
   always @(negedge CLK) begin
      if (RST || px == HT - 1) begin
         ln = RST ? 0 : (ln + 1) % VT;
         px = 0;
      end else begin
         px++;
      end
      H_SYNC = !RST && px < 2;
      V_SYNC = !RST && ln == 0;
   end
endmodule : utpg_raster

// [inc/utpg_map.svh]
`ifndef UTPG_MAP_SVH
`define UTPG_MAP_SVH
// Number of user timing outputs
`define UTPG_NUM_OUT      4
// Base address of the user timing registers in host space
`define UTPG_REG_BASE     8'h57
// Timing registers per output
`define UTPG_REGS_PER_OUT 4
// Register index within one output's group
`define UTPG_IDX_HSTART   2'h0
`define UTPG_IDX_HSTOP    2'h1
`define UTPG_IDX_VSTART   2'h2
`define UTPG_IDX_VSTOP    2'h3
// Counter width (pixels and lines)
`define UTPG_CNT_W        12
// Combine mode encodings
`define UTPG_MODE_H       3'h0
`define UTPG_MODE_V       3'h1
`define UTPG_MODE_AND     3'h2
`define UTPG_MODE_OR      3'h3
`define UTPG_MODE_XOR     3'h4
`endif

// [inc/utpg_pkg.sv]
package utpg_pkg;
   // Combine operation for the horizontal and vertical pulses
   typedef enum logic [2:0] {
      UTPG_H_ONLY = 3'h0,
      UTPG_V_ONLY = 3'h1,
      UTPG_AND    = 3'h2,
      UTPG_OR     = 3'h3,
      UTPG_XOR    = 3'h4
   } utpg_mode_e;

   // Settings of one user output
   typedef struct packed {
      logic [11:0] h_start;
      logic [11:0] h_stop;
      logic [11:0] v_start;
      logic [11:0] v_stop;
      utpg_mode_e  mode;
      logic        active_low;
   } utpg_cfg_s;

   // Raster position counted from the generated sync leading edges
   typedef struct packed {
      logic [11:0] pix;
      logic [11:0] line;
   } utpg_pos_s;
endpackage : utpg_pkg

// [verilog/utpg_pulse.sv]
`timescale 1ns/1ps
`include "utpg_map.svh"
// One user output: window compares, combine, polarity, registered
module utpg_pulse (
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire utpg_pkg::utpg_cfg_s cfg,    // Settings for this output
   input  wire utpg_pkg::utpg_pos_s pos,    // Current raster position
   output      logic                pulse   // Final polarised pulse
);
   // Inclusive window test; start above stop gives no pulse
   function automatic logic in_win(input logic [11:0] c, input logic [11:0] a, input logic [11:0] b);
      in_win = (c >= a) && (c <= b);
   endfunction : in_win

   logic h_on;       // Horizontal window hit
   logic v_on;       // Vertical window hit
   logic comb;       // Combined, still active high

   always_comb begin
      h_on = in_win(pos.pix, cfg.h_start, cfg.h_stop);    // R3 R8
      v_on = in_win(pos.line, cfg.v_start, cfg.v_stop);   // R3 R8
      // Unknown mode codes fall back to AND so the output stays bounded
      case (cfg.mode)   // R7
         utpg_pkg::UTPG_H_ONLY: comb = h_on;
         utpg_pkg::UTPG_V_ONLY: comb = v_on;
         utpg_pkg::UTPG_OR:     comb = h_on | v_on;
         utpg_pkg::UTPG_XOR:    comb = h_on ^ v_on;
         default:               comb = h_on & v_on;
      endcase
   end

   // Register output; reset drives the pulse low whatever the polarity
   always_ff @(posedge CLK) begin
      if (RST) begin
         pulse <= 1'b0;
      end else begin
         pulse <= comb ^ cfg.active_low;   // R2
      end
   end

   a_pulse_polarity: assert property (@(posedge CLK) disable iff (RST)
      $past(!RST) |-> pulse == ($past(comb) ^ $past(cfg.active_low))) else $error("user pulse level wrong"); // R2
   a_and_gate: assert property (@(posedge CLK) disable iff (RST)
      (cfg.mode == utpg_pkg::UTPG_AND && !v_on) ##1 $stable(cfg.active_low) |-> pulse == cfg.active_low)
      else $error("and mode leaked outside lines"); // R7
endmodule : utpg_pulse

// [verilog/utpg_top.sv]
`timescale 1ns/1ps
`include "utpg_map.svh"
// What this block does
// R1 - Four independent user timing outputs
// R2 - Four timing registers plus polarity bit
// R3 - Start/stop in pixels and lines
// R4 - Timing registers start at address 57h
// R5 - Referenced to own generated H/V/F; only the H and V syncs are used here, there is no F input
// R6 - Counts start at sync leading edges
// R7 - Optional AND, OR, XOR combine
// R8 - Pulse asserted while count within window; USER_OUT lags the counts by two clocks
module utpg_top #(
   parameter int CNT_W = `UTPG_CNT_W          // Pixel and line counter width
) (
   input  wire logic       CLK,               // Pixel clock
   input  wire logic       RST,               // Synchronous, active high
   input  wire logic       H_SYNC,            // Generated H sync, active high, same domain
   input  wire logic       V_SYNC,            // Generated V sync, active high, same domain
   input  wire logic       REG_WE,            // Host register write strobe
   input  wire logic [7:0] REG_ADDR,          // Host register address
   input  wire logic [11:0] REG_WDATA,        // Host write data
   input  wire logic [3:0] POL_LOW,           // Per-output active-low select
   input  wire logic [11:0] MODE_SEL,         // Three mode bits per output
   output      logic [11:0] REG_RDATA,        // Read data of addressed register
   output      logic [3:0] USER_OUT,          // The four user pulses
   output      logic [CNT_W-1:0] PIX_COUNT,   // Pixel count since H sync edge
   output      logic [CNT_W-1:0] LINE_COUNT   // Line count since V sync edge
);
   // Refuse widths the 12-bit register and struct fields cannot serve
   if (CNT_W != 12) begin : g_bad_width
      $error("utpg_top supports CNT_W of 12 only");
   end

   localparam int NOUT = `UTPG_NUM_OUT;
   localparam int NREG = NOUT * `UTPG_REGS_PER_OUT;

   logic [11:0] regs [NREG];       // Timing registers, 57h upward
   logic        h_d;               // Delayed H sync for edge find
   logic        v_d;               // Delayed V sync for edge find
   logic        h_lead;            // H sync leading edge
   logic        v_lead;            // V sync leading edge
   logic [7:0]  rel;               // Address relative to base
   utpg_pkg::utpg_pos_s pos;       // Position fed to each output
   utpg_pkg::utpg_cfg_s cfg [NOUT];
   logic [3:0]  pulse;             // Per-output pulses

   // Address decode helper, shared by write and read
   function automatic logic hit(input logic [7:0] a);
      hit = (a >= `UTPG_REG_BASE) && (a < `UTPG_REG_BASE + 8'(NREG));
   endfunction : hit

   assign rel    = REG_ADDR - `UTPG_REG_BASE;
   assign h_lead = H_SYNC & ~h_d;   // R6
   assign v_lead = V_SYNC & ~v_d;   // R6

   // Host writes into the timing register group
   always_ff @(posedge CLK) begin
      if (RST) begin
         for (int i = 0; i < NREG; i++) regs[i] <= 12'h000;
      end else if (REG_WE && hit(REG_ADDR)) begin   // R4
         regs[rel[3:0]] <= REG_WDATA;
      end
   end

   // Read back; unmapped addresses read zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         REG_RDATA <= 12'h000;
      end else if (hit(REG_ADDR)) begin   // R4
         REG_RDATA <= regs[rel[3:0]];
      end else begin
         REG_RDATA <= 12'h000;
      end
   end

   // Sync edge history; syncs come from the own timing generator, so no synchroniser
   always_ff @(posedge CLK) begin
      if (RST) begin
         h_d <= 1'b0;
         v_d <= 1'b0;
      end else begin
         h_d <= H_SYNC;
         v_d <= V_SYNC;
      end
   end

   // Pixel count restarts at zero on each H sync leading edge
   always_ff @(posedge CLK) begin
      if (RST) begin
         PIX_COUNT <= '0;
      end else if (h_lead) begin   // R5 R6
         PIX_COUNT <= '0;
      end else if (PIX_COUNT != '1) begin
         PIX_COUNT <= PIX_COUNT + 1'b1;
      end
   end

   // Line count restarts on V sync leading edge, advances each line
   always_ff @(posedge CLK) begin
      if (RST) begin
         LINE_COUNT <= '0;
      end else if (v_lead) begin   // R5 R6
         LINE_COUNT <= '0;
      end else if (h_lead && LINE_COUNT != '1) begin
         LINE_COUNT <= LINE_COUNT + 1'b1;
      end
   end

   assign pos.pix  = PIX_COUNT;
   assign pos.line = LINE_COUNT;

   // One pulse unit per output, each with its own settings
   for (genvar g = 0; g < NOUT; g++) begin : g_out   // R1
      always_comb begin
         cfg[g].h_start    = regs[4*g + 0];   // R2 R3
         cfg[g].h_stop     = regs[4*g + 1];
         cfg[g].v_start    = regs[4*g + 2];
         cfg[g].v_stop     = regs[4*g + 3];
         cfg[g].mode       = utpg_pkg::utpg_mode_e'(MODE_SEL[3*g +: 3]);
         cfg[g].active_low = POL_LOW[g];
      end
      utpg_pulse u_pulse (
         .CLK   (CLK),
         .RST   (RST),
         .cfg   (cfg[g]),
         .pos   (pos),
         .pulse (pulse[g])
      );
   end

   // Outputs straight from a flop; one extra pipeline stage
   always_ff @(posedge CLK) begin
      if (RST) begin
         USER_OUT <= 4'h0;
      end else begin
         USER_OUT <= pulse;   // R1
      end
   end

   a_pix_restart: assert property (@(posedge CLK) disable iff (RST)
      h_lead |=> PIX_COUNT == '0) else $error("pixel count not restarted"); // R6
   a_line_restart: assert property (@(posedge CLK) disable iff (RST)
      v_lead |=> LINE_COUNT == '0) else $error("line count not restarted"); // R5
   a_out_follow: assert property (@(posedge CLK) disable iff (RST)
      $past(!RST) |-> USER_OUT == $past(pulse)) else $error("output stage lag wrong"); // R1
   a_reg_write: assert property (@(posedge CLK) disable iff (RST)
      (REG_WE && REG_ADDR == `UTPG_REG_BASE) |=> regs[0] == $past(REG_WDATA)) else $error("base write lost"); // R4
endmodule : utpg_top
